// [design/oscillator_config_registers.sv]
// byte-wide configuration register bank of a programmable oscillator
`timescale 1ns/10ps

module oscillator_config_registers #(
  parameter logic [7:0] DEVICE_KIND = 8'h5A  // arbitrary value
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        oe_pin,
  output logic      [7:0]  reg_rdata_q,
  output logic             reg_hit_q,
  output logic             device_reset_q,
  output logic             calibration_start_q,
  output logic             output_enable_q,
  output logic             calibration_bypass_q,
  output logic      [10:0] high_speed_divider_q,
  output logic      [2:0]  power_of_two_divider_q,
  output logic      [42:0] feedback_divider_q,
  output logic      [23:0] fine_frequency_offset_q,
  output logic      [1:0]  page_q
);

  // ********************************************************************
  // pin synchroniser and address decode
  // ********************************************************************
  logic       oe_meta_q;
  logic       oe_sync_q;
  logic [9:0] full_addr;
  logic       page_ok;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      oe_meta_q <= 1'b0;
      oe_sync_q <= 1'b0;
    end else begin
      oe_meta_q <= oe_pin;
      oe_sync_q <= oe_meta_q;
    end
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r,
                               input logic ok);
    hit = ok && (a == r);
  endfunction

  logic [7:0] page_reg;

  // page register forms upper address bits
  assign full_addr = {page_reg[1:0], reg_addr};
  // the page register itself answers on every page
  assign page_ok   = (full_addr[9:8] == osc_cfg_pkg::PAGE_MAP);

  logic wr_rst_cal;
  logic wr_out_ovr;
  logic wr_hs_lo;
  logic wr_pack;
  logic [5:0] wr_fb;
  logic wr_cal_byp;
  logic wr_fine0;
  logic wr_fine1;
  logic wr_fine2;
  logic wr_page;

  assign wr_rst_cal = reg_wr && hit(reg_addr, osc_cfg_pkg::ADDR_RST_CAL,
                                    page_ok);
  assign wr_out_ovr = reg_wr && hit(reg_addr, osc_cfg_pkg::ADDR_OUT_OVR,
                                    page_ok);
  assign wr_hs_lo   = reg_wr && hit(reg_addr, osc_cfg_pkg::ADDR_HIGH_SPEED_DIVIDER_LO,
                                    page_ok);
  assign wr_pack    = reg_wr && hit(reg_addr, osc_cfg_pkg::ADDR_DIV_PACK,
                                    page_ok);
  assign wr_fb[0]   = reg_wr && hit(reg_addr, osc_cfg_pkg::ADDR_FB0, page_ok);
  assign wr_fb[1]   = reg_wr && hit(reg_addr, osc_cfg_pkg::ADDR_FB1, page_ok);
  assign wr_fb[2]   = reg_wr && hit(reg_addr, osc_cfg_pkg::ADDR_FB2, page_ok);
  assign wr_fb[3]   = reg_wr && hit(reg_addr, osc_cfg_pkg::ADDR_FB3, page_ok);
  assign wr_fb[4]   = reg_wr && hit(reg_addr, osc_cfg_pkg::ADDR_FB4, page_ok);
  assign wr_fb[5]   = reg_wr && hit(reg_addr, osc_cfg_pkg::ADDR_FB_TOP,
                                    page_ok);
  assign wr_cal_byp = reg_wr && hit(reg_addr, osc_cfg_pkg::ADDR_CAL_BYP,
                                    page_ok);
  assign wr_fine0   = reg_wr && hit(reg_addr, osc_cfg_pkg::ADDR_FINE0,
                                    page_ok);
  assign wr_fine1   = reg_wr && hit(reg_addr, osc_cfg_pkg::ADDR_FINE1,
                                    page_ok);
  assign wr_fine2   = reg_wr && hit(reg_addr, osc_cfg_pkg::ADDR_FINE2,
                                    page_ok);
  assign wr_page    = reg_wr && (reg_addr == osc_cfg_pkg::ADDR_PAGE);

  // ********************************************************************
  // storage registers
  // ********************************************************************
  logic [7:0] out_ovr_reg;
  logic [7:0] hs_lo_reg;
  logic [7:0] pack_reg;
  logic [7:0] fb_reg [0:5];
  logic [7:0] cal_byp_reg;
  logic [7:0] fine0_reg;
  logic [7:0] fine1_reg;
  logic [7:0] fine2_reg;

  osc_cfg_byte_reg #(
    .RESET_VAL (osc_cfg_pkg::RST_OUT_OVR),
    .WR_MASK   (8'h01),
    .FIXED_VAL (8'h00)
  ) u_out_ovr (
    .ref_clk (ref_clk),
    .rst     (rst),
    .wr_en   (wr_out_ovr),
    .wr_data (reg_wdata),
    .value_q (out_ovr_reg)
  );

  osc_cfg_byte_reg #(
    .RESET_VAL (osc_cfg_pkg::RST_HIGH_SPEED_DIVIDER_LO)
  ) u_hs_lo (
    .ref_clk (ref_clk),
    .rst     (rst),
    .wr_en   (wr_hs_lo),
    .wr_data (reg_wdata),
    .value_q (hs_lo_reg)
  );

  osc_cfg_byte_reg #(
    .RESET_VAL (osc_cfg_pkg::RST_DIV_PACK),
    .WR_MASK   (osc_cfg_pkg::MASK_DIV_PACK)
  ) u_pack (
    .ref_clk (ref_clk),
    .rst     (rst),
    .wr_en   (wr_pack),
    .wr_data (reg_wdata),
    .value_q (pack_reg)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_fb
      localparam logic [7:0] RV = (gi == 4) ? osc_cfg_pkg::RST_FB4 :
                                  (gi == 5) ? osc_cfg_pkg::RST_FB_TOP :
                                              osc_cfg_pkg::RST_FB_LOW;
      localparam logic [7:0] MK = (gi == 5) ? osc_cfg_pkg::MASK_FB_TOP :
                                              8'hFF;
      osc_cfg_byte_reg #(
        .RESET_VAL (RV),
        .WR_MASK   (MK)
      ) u_fb (
        .ref_clk (ref_clk),
        .rst     (rst),
        .wr_en   (wr_fb[gi]),
        .wr_data (reg_wdata),
        .value_q (fb_reg[gi])
      );
    end
  endgenerate

  osc_cfg_byte_reg #(
    .RESET_VAL (osc_cfg_pkg::RST_CAL_BYP),
    .WR_MASK   (8'h80),
    .FIXED_VAL ({1'b0, osc_cfg_pkg::CAL_BYP_RSVD})
  ) u_cal_byp (
    .ref_clk (ref_clk),
    .rst     (rst),
    .wr_en   (wr_cal_byp),
    .wr_data (reg_wdata),
    .value_q (cal_byp_reg)
  );

  osc_cfg_byte_reg #(
    .RESET_VAL (osc_cfg_pkg::RST_FINE)
  ) u_fine0 (
    .ref_clk (ref_clk),
    .rst     (rst),
    .wr_en   (wr_fine0),
    .wr_data (reg_wdata),
    .value_q (fine0_reg)
  );

  osc_cfg_byte_reg #(
    .RESET_VAL (osc_cfg_pkg::RST_FINE)
  ) u_fine1 (
    .ref_clk (ref_clk),
    .rst     (rst),
    .wr_en   (wr_fine1),
    .wr_data (reg_wdata),
    .value_q (fine1_reg)
  );

  osc_cfg_byte_reg #(
    .RESET_VAL (osc_cfg_pkg::RST_FINE)
  ) u_fine2 (
    .ref_clk (ref_clk),
    .rst     (rst),
    .wr_en   (wr_fine2),
    .wr_data (reg_wdata),
    .value_q (fine2_reg)
  );

  osc_cfg_byte_reg #(
    .RESET_VAL (osc_cfg_pkg::RST_PAGE),
    .WR_MASK   (osc_cfg_pkg::MASK_PAGE)
  ) u_page (
    .ref_clk (ref_clk),
    .rst     (rst),
    .wr_en   (wr_page),
    .wr_data (reg_wdata),
    .value_q (page_reg)
  );

  // ********************************************************************
  // self-clearing pulses, outputs and read mux
  // ********************************************************************
  logic        device_reset_d;
  logic        calibration_start_d;
  logic        output_enable_d;
  logic [23:0] fine_frequency_offset_d;
  logic [7:0]  reg_rdata_d;
  logic        reg_hit_d;
  logic        calibration_bypass_d;
  logic [10:0] high_speed_divider_d;
  logic [2:0]  power_of_two_divider_d;
  logic [42:0] feedback_divider_d;
  logic [1:0]  page_d;

  always_comb begin
    // one-cycle pulses, register reads back zero
    device_reset_d = wr_rst_cal &&
                     reg_wdata[osc_cfg_pkg::BIT_DEV_RESET];
    calibration_start_d = wr_rst_cal &&
                          reg_wdata[osc_cfg_pkg::BIT_CAL_START];
    output_enable_d = out_ovr_reg[osc_cfg_pkg::BIT_OVERRIDE] &&
                      oe_sync_q;
    calibration_bypass_d =
      cal_byp_reg[osc_cfg_pkg::BIT_CAL_BYPASS];
    high_speed_divider_d   = {pack_reg[2:0], hs_lo_reg};
    power_of_two_divider_d = pack_reg[6:4];
    feedback_divider_d     = {fb_reg[5][2:0], fb_reg[4], fb_reg[3],
                              fb_reg[2], fb_reg[1], fb_reg[0]};
    page_d                 = page_reg[1:0];
    fine_frequency_offset_d = fine_frequency_offset_q;
    if (wr_fine2) begin
      fine_frequency_offset_d = {reg_wdata, fine1_reg, fine0_reg};
    end
    reg_rdata_d = reg_rdata_q;
    reg_hit_d   = reg_hit_q;
    if (reg_rd) begin
      reg_hit_d = page_ok;
      if (reg_addr == osc_cfg_pkg::ADDR_PAGE) begin
        reg_hit_d   = 1'b1;
        reg_rdata_d = page_reg;
      end else if (!page_ok) begin
        reg_rdata_d = 8'h00;
      end else begin
        case (reg_addr)
          osc_cfg_pkg::ADDR_KIND_ID:  reg_rdata_d = DEVICE_KIND;
          osc_cfg_pkg::ADDR_RST_CAL:  reg_rdata_d = osc_cfg_pkg::RST_RST_CAL;
          osc_cfg_pkg::ADDR_OUT_OVR:  reg_rdata_d = out_ovr_reg;
          osc_cfg_pkg::ADDR_HIGH_SPEED_DIVIDER_LO: reg_rdata_d = hs_lo_reg;
          osc_cfg_pkg::ADDR_DIV_PACK: reg_rdata_d = pack_reg;
          osc_cfg_pkg::ADDR_FB0:      reg_rdata_d = fb_reg[0];
          osc_cfg_pkg::ADDR_FB1:      reg_rdata_d = fb_reg[1];
          osc_cfg_pkg::ADDR_FB2:      reg_rdata_d = fb_reg[2];
          osc_cfg_pkg::ADDR_FB3:      reg_rdata_d = fb_reg[3];
          osc_cfg_pkg::ADDR_FB4:      reg_rdata_d = fb_reg[4];
          osc_cfg_pkg::ADDR_FB_TOP:   reg_rdata_d = fb_reg[5];
          osc_cfg_pkg::ADDR_CAL_BYP:  reg_rdata_d = cal_byp_reg;
          osc_cfg_pkg::ADDR_FINE0:    reg_rdata_d = fine0_reg;
          osc_cfg_pkg::ADDR_FINE1:    reg_rdata_d = fine1_reg;
          osc_cfg_pkg::ADDR_FINE2:    reg_rdata_d = fine2_reg;
          default: begin
            reg_rdata_d = 8'h00;
            reg_hit_d   = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      device_reset_q          <= 1'b0;
      calibration_start_q     <= 1'b0;
      output_enable_q         <= 1'b0;
      fine_frequency_offset_q <= 24'h000000;
      reg_rdata_q             <= 8'h00;
      reg_hit_q               <= 1'b0;
      calibration_bypass_q    <=
        osc_cfg_pkg::RST_CAL_BYP[osc_cfg_pkg::BIT_CAL_BYPASS];
      high_speed_divider_q    <= {osc_cfg_pkg::RST_DIV_PACK[2:0],
                                  osc_cfg_pkg::RST_HIGH_SPEED_DIVIDER_LO};
      power_of_two_divider_q  <= osc_cfg_pkg::RST_DIV_PACK[6:4];
      feedback_divider_q      <= {osc_cfg_pkg::RST_FB_TOP[2:0],
                                  osc_cfg_pkg::RST_FB4,
                                  {4{osc_cfg_pkg::RST_FB_LOW}}};
      page_q                  <= osc_cfg_pkg::RST_PAGE[1:0];
    end else begin
      device_reset_q          <= device_reset_d;
      calibration_start_q     <= calibration_start_d;
      output_enable_q         <= output_enable_d;
      fine_frequency_offset_q <= fine_frequency_offset_d;
      reg_rdata_q             <= reg_rdata_d;
      reg_hit_q               <= reg_hit_d;
      calibration_bypass_q    <= calibration_bypass_d;
      high_speed_divider_q    <= high_speed_divider_d;
      power_of_two_divider_q  <= power_of_two_divider_d;
      feedback_divider_q      <= feedback_divider_d;
      page_q                  <= page_d;
    end
  end

endmodule

// [design/osc_cfg_pkg.sv]
// constants for the oscillator configuration register bank
package osc_cfg_pkg;

  // ********************************************************************
  // register addresses (8-bit offsets within a page)
  // ********************************************************************
  localparam logic [7:0] ADDR_KIND_ID    = 8'h00;
  localparam logic [7:0] ADDR_RST_CAL    = 8'h07;
  localparam logic [7:0] ADDR_OUT_OVR    = 8'h11;
  localparam logic [7:0] ADDR_HIGH_SPEED_DIVIDER_LO   = 8'h17;
  localparam logic [7:0] ADDR_DIV_PACK   = 8'h18;
  localparam logic [7:0] ADDR_FB0        = 8'h1A;
  localparam logic [7:0] ADDR_FB1        = 8'h1B;
  localparam logic [7:0] ADDR_FB2        = 8'h1C;
  localparam logic [7:0] ADDR_FB3        = 8'h1D;
  localparam logic [7:0] ADDR_FB4        = 8'h1E;
  localparam logic [7:0] ADDR_FB_TOP     = 8'h1F;
  localparam logic [7:0] ADDR_CAL_BYP    = 8'h45;
  localparam logic [7:0] ADDR_FINE0      = 8'hE7;
  localparam logic [7:0] ADDR_FINE1      = 8'hE8;
  localparam logic [7:0] ADDR_FINE2      = 8'hE9;
  localparam logic [7:0] ADDR_PAGE       = 8'hFF;

  // ********************************************************************
  // page of the register map, reset values, field positions
  // ********************************************************************
  localparam logic [1:0] PAGE_MAP        = 2'h0;
  localparam logic [7:0] RST_RST_CAL     = 8'h00;
  localparam logic [7:0] RST_OUT_OVR     = 8'h01;
  localparam logic [7:0] RST_HIGH_SPEED_DIVIDER_LO    = 8'h54;
  localparam logic [7:0] RST_DIV_PACK    = 8'h00;
  localparam logic [7:0] RST_FB_LOW      = 8'h00;
  localparam logic [7:0] RST_FB4         = 8'h64;
  localparam logic [7:0] RST_FB_TOP      = 8'h00;
  localparam logic [7:0] RST_CAL_BYP     = 8'h01;
  localparam logic [7:0] RST_FINE        = 8'h00;
  localparam logic [7:0] RST_PAGE        = 8'h00;
  localparam logic [6:0] CAL_BYP_RSVD    = 7'h01;
  localparam int         BIT_DEV_RESET   = 7;
  localparam int         BIT_CAL_START   = 3;
  localparam int         BIT_OVERRIDE    = 0;
  localparam int         BIT_CAL_BYPASS  = 7;
  localparam logic [7:0] MASK_DIV_PACK   = 8'h77;
  localparam logic [7:0] MASK_FB_TOP     = 8'h07;
  localparam logic [7:0] MASK_PAGE       = 8'h03;

endpackage

// [design/osc_cfg_byte_reg.sv]
// one byte-wide configuration register with reset value and write mask
`timescale 1ns/10ps
module osc_cfg_byte_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WR_MASK   = 8'hFF,
  parameter logic [7:0] FIXED_VAL = 8'h00
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] value_q
);

  logic [7:0] value_d;

  // masked bits keep their fixed value
  always_comb begin
    value_d = value_q;
    if (wr_en) begin
      value_d = (wr_data & WR_MASK) | (FIXED_VAL & ~WR_MASK);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      value_q <= RESET_VAL;
    end else begin
      value_q <= value_d;
    end
  end

endmodule

// [tb/osc_cfg_monitor.sv]
// assertion checker for the oscillator register bank
`timescale 1ns/10ps
module osc_cfg_monitor #(
  parameter logic [7:0] DEVICE_KIND = 8'h5A // arbitrary value
) (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata_q,
  input wire logic        reg_hit_q,
  input wire logic        device_reset_q,
  input wire logic        calibration_start_q,
  input wire logic        output_enable_q,
  input wire logic        calibration_bypass_q,
  input wire logic [23:0] fine_frequency_offset_q,
  input wire logic [1:0]  page_q
);
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence wr_at(a);
    reg_wr && reg_addr == a && page_q == 2'h0;
  endsequence
  sequence pulse(s);
    s ##1 !s;
  endsequence
  cal_pulse_a: assert property (wr_at(8'h07) ##0 reg_wdata[3]
    |=> pulse(calibration_start_q)) else $error("calibration pulse wrong");
  rst_pulse_a: assert property (wr_at(8'h07) ##0 reg_wdata[7]
    |=> pulse(device_reset_q)) else $error("reset pulse wrong");
  kind_read_a: assert property (
    reg_rd && !reg_wr && reg_addr == 8'h00 && page_q == 2'h0 |=>
    reg_hit_q && reg_rdata_q == DEVICE_KIND) else $error("type byte wrong");
  page_miss_a: assert property (
    reg_rd && !reg_wr && page_q != 2'h0 && reg_addr != 8'hFF |=>
    !reg_hit_q && reg_rdata_q == 8'h00) else $error("other page answered");
  ovr_off_a: assert property (wr_at(8'h11) ##0 !reg_wdata[0]
    |-> ##2 !output_enable_q [*2]) else $error("output not disabled");
  fine_hold_a: assert property (
    !(reg_wr && reg_addr == 8'hE9 && page_q == 2'h0) |=>
    $stable(fine_frequency_offset_q)) else $error("offset moved early");
  fine_load_a: assert property (wr_at(8'hE9) |=>
    fine_frequency_offset_q[23:16] == $past(reg_wdata))
    else $error("offset top byte wrong");
  page_out_a: assert property (reg_wr && reg_addr == 8'hFF |->
    ##2 {6'h00, page_q} == ($past(reg_wdata, 2) & 8'h03))
    else $error("page bits wrong");
  byp_out_a: assert property (wr_at(8'h45) |->
    ##2 {calibration_bypass_q, 7'h00} == ($past(reg_wdata, 2) & 8'h80))
    else $error("bypass bit wrong");
endmodule

bind oscillator_config_registers osc_cfg_monitor #(
  .DEVICE_KIND(DEVICE_KIND)
) i_osc_cfg_monitor (
  .ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
  .reg_hit_q(reg_hit_q), .device_reset_q(device_reset_q),
  .calibration_start_q(calibration_start_q),
  .output_enable_q(output_enable_q),
  .calibration_bypass_q(calibration_bypass_q),
  .fine_frequency_offset_q(fine_frequency_offset_q), .page_q(page_q)
);

// [tb/osc_cfg_host.sv]
// host model that reads and writes the configuration registers
`timescale 1ns/10ps
module osc_cfg_host (
  input  wire logic       ref_clk,
  input  wire logic [7:0] reg_rdata_q,
  input  wire logic       reg_hit_q,
  output logic            reg_wr = 1'b0,
  output logic            reg_rd = 1'b0,
  output logic      [7:0] reg_addr = 8'h00,
  output logic      [7:0] reg_wdata = 8'h00
);
  // ****************************************
  // bus cycles, changed on the falling edge
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    @(negedge ref_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = a == 8'h45 ? {x[7], 7'h01} : x;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~reg_wdata;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] dv,
                    output logic hv);
    @(negedge ref_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    dv = reg_rdata_q;
    hv = reg_hit_q;
  endtask
endmodule

// [tb/oscillator_config_registers_bench.sv]
// self-checking bench for the oscillator register bank
`timescale 1ns/10ps
module oscillator_config_registers_bench;
  localparam logic [7:0] KIND = 8'h3C; // arbitrary value
  logic        ref_clk, rst, oe_pin, reg_wr, reg_rd, reg_hit_q, h;
  logic        dev_rst, cal_go, oe_out, byp;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata_q, d;
  logic [10:0] hsd;
  logic [2:0]  p2d;
  logic [42:0] fbd;
  logic [23:0] fine;
  logic [1:0]  page;
  logic [31:0] v;
  int          error_cnt = 0, checked = 0, cyc = 0, fine_e;
  int          mdl[int];
  // ****************************************
  // design, host model, clock
  // ****************************************
  oscillator_config_registers #(.DEVICE_KIND(KIND))
    i_oscillator_config_registers (
    .ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .oe_pin(oe_pin),
    .reg_rdata_q(reg_rdata_q), .reg_hit_q(reg_hit_q),
    .device_reset_q(dev_rst), .calibration_start_q(cal_go),
    .output_enable_q(oe_out), .calibration_bypass_q(byp),
    .high_speed_divider_q(hsd), .power_of_two_divider_q(p2d),
    .feedback_divider_q(fbd), .fine_frequency_offset_q(fine),
    .page_q(page));
  osc_cfg_host host (
    .ref_clk(ref_clk), .reg_rdata_q(reg_rdata_q), .reg_hit_q(reg_hit_q),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      summarize();
    end
  end
  task automatic chk(input string n, input logic [63:0] e, g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %0h seen %0h", n, e, g);
    end
  endtask
  function automatic int wv(int a, int x);
    case (a)
      8'h07: return 0;
      8'h11: return x & 8'h01;
      8'h18: return x & 8'h77;
      8'h1F: return x & 8'h07;
      8'h45: return (x & 8'h80) | 8'h01;
      8'hFF: return x & 8'h03;
      default: return x & 8'hFF;
    endcase
  endfunction
  task automatic init_mdl();
    fine_e = 0;
    mdl = '{8'h07:0, 8'h11:1, 8'h17:8'h54, 8'h18:0, 8'h1A:0, 8'h1B:0,
            8'h1C:0, 8'h1D:0, 8'h1E:8'h64, 8'h1F:0, 8'h45:1, 8'hE7:0,
            8'hE8:0, 8'hE9:0, 8'hFF:0};
  endtask
  task automatic w(input int a, input int x);
    host.wr(a[7:0], x[7:0]);
    if (mdl[8'hFF] == 0 && a == 8'hE9)
      fine_e = {x[7:0], mdl[8'hE8][7:0], mdl[8'hE7][7:0]};
    if (a == 8'hFF || (mdl[8'hFF] == 0 && a != 0 && mdl.exists(a)))
      mdl[a] = wv(a, x);
  endtask
  task automatic r(input int a);
    logic eh;
    int   e;
    eh = a == 8'hFF || (mdl[8'hFF] == 0 && (a == 0 || mdl.exists(a)));
    e = !eh ? 0 : a == 0 ? KIND : mdl[a];
    host.rd(a[7:0], d, h);
    chk("rdata", e, d);
    chk("hit", eh, h);
  endtask
  task automatic outs();
    chk("hs_div", {mdl[8'h18][2:0], mdl[8'h17][7:0]}, hsd);
    chk("p2_div", mdl[8'h18][6:4], p2d);
    chk("fb_div", {mdl[8'h1F][2:0], mdl[8'h1E][7:0], mdl[8'h1D][7:0],
        mdl[8'h1C][7:0], mdl[8'h1B][7:0], mdl[8'h1A][7:0]}, fbd);
    chk("bypass", mdl[8'h45][7], byp);
    chk("fine", fine_e, fine);
    chk("page", mdl[8'hFF], page);
  endtask
  task automatic sweep();
    foreach (mdl[a]) r(a);
    r(8'h00);
    outs();
  endtask
  task automatic oe_case(input int ov, input logic pin);
    oe_pin = pin;
    w(8'h11, ov);
    repeat (4) @(negedge ref_clk);
    chk("oe_out", ov[0] & pin, oe_out);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    v = $urandom(59);
    rst = 1'b1;
    oe_pin = 1'b1;
    init_mdl();
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    sweep();
    foreach (mdl[a]) if (a != 8'hFF) w(a, $urandom);
    w(8'h00, $urandom);
    repeat (2) @(negedge ref_clk);
    sweep();
    r(8'h02);
    host.wr(8'h07, 8'h88);
    chk("pulse_on", 8'h03, {dev_rst, cal_go});
    @(negedge ref_clk);
    chk("pulse_off", 8'h00, {dev_rst, cal_go});
    r(8'h07);
    oe_case(0, 1'b1);
    oe_case(1, 1'b1);
    oe_case(1, 1'b0);
    oe_case(0, 1'b0);
    v = $urandom;
    w(8'hE7, v[7:0]);
    w(8'hE8, v[15:8]);
    outs();
    w(8'hE9, v[23:16]);
    outs();
    w(8'hFF, 8'hFD);
    repeat (2) @(negedge ref_clk);
    outs();
    r(8'h17);
    r(8'hFF);
    w(8'h17, 8'hAA);
    w(8'hFF, 8'h00);
    repeat (2) @(negedge ref_clk);
    sweep();
    rst = 1'b1;
    init_mdl();
    repeat (2) @(negedge ref_clk);
    outs();
    chk("rst_out", 0, {dev_rst, cal_go, oe_out});
    rst = 1'b0;
    sweep();
    summarize();
  end
endmodule
